// file: core/sfacb_pkg.sv
// Shared constants and types for the status-flag, add, call and branch unit
package sfacb_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CYC1 = 3'b010,
        ST_CYC2 = 3'b100
    } sfacb_state_t;
    // ****************************
    // Register map
    // ****************************
    localparam int AXI_AW = 12;
    localparam logic [11:0] OFF_CMD = 12'h000;
    localparam logic [11:0] OFF_STAT = 12'h004;
    localparam logic [11:0] OFF_ACC = 12'h008;
    localparam logic [11:0] OFF_B = 12'h00c;
    localparam logic [11:0] OFF_PSW = 12'h010;
    localparam logic [11:0] OFF_PC = 12'h014;
    localparam logic [11:0] OFF_SP = 12'h018;
    localparam logic [11:0] OFF_DATA_POINTER = 12'h01c;
    localparam logic [1:0] RAM_WIN = 2'h1;
    localparam int CMD_START_BIT = 24;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************
    // Status word layout and reset values
    // ****************************
    localparam int PSW_CY = 7;
    localparam int PSW_AC = 6;
    localparam int PSW_F0 = 5;
    localparam int PSW_RS1 = 4;
    localparam int PSW_RS0 = 3;
    localparam int PSW_OV = 2;
    localparam int PSW_RSV = 1;
    localparam int PSW_P = 0;
    localparam logic [7:0] PSW_RST = 8'h00;
    localparam logic [7:0] SP_RST = 8'h07;
    // ****************************
    // Special register and bit addresses
    // ****************************
    localparam logic [7:0] SFR_ACC = 8'he0;
    localparam logic [7:0] SFR_B = 8'hf0;
    localparam logic [7:0] SFR_PSW = 8'hd0;
    localparam logic [7:0] SFR_SP = 8'h81;
    localparam logic [7:0] SFR_DPL = 8'h82;
    localparam logic [7:0] SFR_DPH = 8'h83;
    localparam logic [3:0] BIT_RAM_HI = 4'h2;
    // ****************************
    // Opcodes
    // ****************************
    localparam logic [3:0] NIB_ADD = 4'h2;
    localparam logic [3:0] NIB_ADD_WITH_CARRY = 4'h3;
    localparam logic [3:0] NIB_CJNE = 4'hb;
    localparam logic [4:0] ABSOLUTE_CALL_LOW = 5'h11;
    localparam logic [4:0] DJNZ_RN = 5'h1b;
    localparam logic [7:0] OP_SJMP = 8'h80;
    localparam logic [7:0] OP_JZ = 8'h60;
    localparam logic [7:0] OP_JNZ = 8'h70;
    localparam logic [7:0] OP_JMPA = 8'h73;
    localparam logic [7:0] OP_DJNZD = 8'hd5;
    localparam logic [7:0] OP_MUL = 8'ha4;
    localparam logic [7:0] OP_DIV = 8'h84;
    localparam logic [7:0] OP_CLRC = 8'hc3;
    localparam logic [7:0] OP_SETBC = 8'hd3;
    localparam logic [7:0] OP_CPLC = 8'hb3;
    localparam logic [7:0] OP_CLRB = 8'hc2;
    localparam logic [7:0] OP_SETBB = 8'hd2;
    localparam logic [7:0] OP_CPLB = 8'hb2;
    localparam int REL_FWD = 127;
    localparam int REL_BACK = 128;
endpackage

// file: core/sfacb_core.sv
// Status word, add, absolute call and branch execution unit with register slave
// Operation
// - Relative target is next address plus signed byte
// - Branch on accumulator zero or non-zero
// - Compare-branch-unequal and decrement-branch-nonzero, relative
// - Indirect jump to pointer plus unsigned accumulator
// - Status word: four flags, user, bank, reserved
// - Bank bits pick one of four banks
// - Carry from add carry-out or compare borrow
// - Carry is Boolean accumulator and addressable bit
// - Auxiliary carry from bit 3 carry-out
// - Add overflow is carry6 xor carry7
// - Overflow on wide product or zero divisor
// - Parity bit 0 tracks accumulator every cycle
// - Direct or bit writes change any flag except parity
// - Add updates accumulator and flags, one cycle
// - Add has register, direct, indirect, immediate forms
// - Add-with-carry includes carry flag, one cycle
// - Call pushes return address low byte first
// - Call target stays in current 2K block
// - Call keeps flags, two bytes, two cycles
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sfacb_core (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Write address channel
    input wire logic [sfacb_pkg::AXI_AW-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // Write data channel
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // Write response channel
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // Read address channel
    input wire logic [sfacb_pkg::AXI_AW-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    // Read data channel
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    // ****************************
    // State
    // ****************************
    sfacb_pkg::sfacb_state_t state;
    logic [7:0] ram [0:255];
    logic [7:0] acc, b, program_status_word, sp, op, b2, b3;
    logic [15:0] pc, data_pointer, target_q;
    logic bad_op;
    logic [7:0] next_acc, next_b, next_psw, next_sp;
    logic [15:0] next_data_pointer, next_target;
    logic [1:0] next_len;
    logic next_two, next_legal;
    logic ram_we;
    logic [7:0] ram_wa, ram_wd;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    // ****************************
    // Bus slave
    // ****************************
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic aw_full, w_full;
    wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
    wire w_take = s_axi_wvalid_i & s_axi_wready_o;
    wire is_idle = (state == sfacb_pkg::ST_IDLE);
    wire do_wr = aw_full & w_full & ~s_axi_bvalid_o & is_idle;
    wire wr_ram = (aw_addr_q[11:10] == sfacb_pkg::RAM_WIN);
    wire wr_cmd = do_wr && aw_addr_q == sfacb_pkg::OFF_CMD;
    wire wr_acc = do_wr && aw_addr_q == sfacb_pkg::OFF_ACC && w_strb_q[0];
    wire wr_b = do_wr && aw_addr_q == sfacb_pkg::OFF_B && w_strb_q[0];
    wire wr_psw = do_wr && aw_addr_q == sfacb_pkg::OFF_PSW && w_strb_q[0];
    wire wr_pc = do_wr && aw_addr_q == sfacb_pkg::OFF_PC;
    wire wr_sp = do_wr && aw_addr_q == sfacb_pkg::OFF_SP && w_strb_q[0];
    wire wr_data_pointer = do_wr && aw_addr_q == sfacb_pkg::OFF_DATA_POINTER;
    wire wr_mapped = wr_ram | (aw_addr_q == sfacb_pkg::OFF_CMD)
        | (aw_addr_q == sfacb_pkg::OFF_STAT) | (aw_addr_q == sfacb_pkg::OFF_ACC)
        | (aw_addr_q == sfacb_pkg::OFF_B) | (aw_addr_q == sfacb_pkg::OFF_PSW)
        | (aw_addr_q == sfacb_pkg::OFF_PC) | (aw_addr_q == sfacb_pkg::OFF_SP)
        | (aw_addr_q == sfacb_pkg::OFF_DATA_POINTER);
    wire start = wr_cmd & w_strb_q[3] & w_data_q[sfacb_pkg::CMD_START_BIT];

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= sfacb_pkg::RESP_OK;
            aw_addr_q <= 12'h000;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr_i;
                aw_full <= 1'b1;
                s_axi_awready_o <= 1'b0;
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata_i;
                w_strb_q <= s_axi_wstrb_i;
                w_full <= 1'b1;
                s_axi_wready_o <= 1'b0;
            end
            if (do_wr) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_mapped ? sfacb_pkg::RESP_OK : sfacb_pkg::RESP_SLVERR;
                aw_full <= 1'b0;
                w_full <= 1'b0;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    wire [11:0] ra = s_axi_araddr_i;
    wire ar_take = s_axi_arvalid_i & s_axi_arready_o;
    wire rd_ram = (ra[11:10] == sfacb_pkg::RAM_WIN);
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        rd_val = 32'h0000_0000;
        if (rd_ram) rd_val = {24'h000000, ram[ra[9:2]]};
        else if (ra == sfacb_pkg::OFF_CMD) rd_val = {8'h00, b3, b2, op};
        else if (ra == sfacb_pkg::OFF_STAT) rd_val = {30'h0, bad_op, ~is_idle};
        else if (ra == sfacb_pkg::OFF_ACC) rd_val = {24'h000000, acc};
        else if (ra == sfacb_pkg::OFF_B) rd_val = {24'h000000, b};
        else if (ra == sfacb_pkg::OFF_PSW) rd_val = {24'h000000, program_status_word};
        else if (ra == sfacb_pkg::OFF_PC) rd_val = {16'h0000, pc};
        else if (ra == sfacb_pkg::OFF_SP) rd_val = {24'h000000, sp};
        else if (ra == sfacb_pkg::OFF_DATA_POINTER) rd_val = {16'h0000, data_pointer};
        else rd_ok = 1'b0;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= sfacb_pkg::RESP_OK;
        end else if (ar_take) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_val;
            s_axi_rresp_o <= rd_ok ? sfacb_pkg::RESP_OK : sfacb_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

    // ****************************
    // Operand fetch and decode
    // ****************************
    wire is_c1 = (state == sfacb_pkg::ST_CYC1);
    wire is_c2 = (state == sfacb_pkg::ST_CYC2);
    wire [1:0] bank = program_status_word[sfacb_pkg::PSW_RS1:sfacb_pkg::PSW_RS0];
    wire [7:0] rn_addr = {3'h0, bank, op[2:0]};
    wire [7:0] ri_addr = {3'h0, bank, 2'h0, op[0]};
    wire [7:0] rn_val = ram[rn_addr];
    wire [7:0] ri_val = ram[ram[ri_addr]];
    wire is_add = (op[7:4] == sfacb_pkg::NIB_ADD) && (op[3] | op[2]);
    wire is_add_with_carry = (op[7:4] == sfacb_pkg::NIB_ADD_WITH_CARRY) && (op[3] | op[2]);
    wire is_cjne = (op[7:4] == sfacb_pkg::NIB_CJNE) && (op[3] | op[2]);
    wire is_absolute_call = (op[4:0] == sfacb_pkg::ABSOLUTE_CALL_LOW);
    wire is_djnz_r = (op[7:3] == sfacb_pkg::DJNZ_RN);
    wire is_djnz_d = (op == sfacb_pkg::OP_DJNZD);
    wire is_bitop = (op == sfacb_pkg::OP_CLRB) | (op == sfacb_pkg::OP_SETBB)
        | (op == sfacb_pkg::OP_CPLB);
    // Bit address 0x80 and up lands in a special register byte
    wire [7:0] dir_addr = !is_bitop ? b2 : b2[7] ? {b2[7:3], 3'h0}
        : {sfacb_pkg::BIT_RAM_HI, b2[6:3]};
    wire [7:0] dir_val = (dir_addr == sfacb_pkg::SFR_ACC) ? acc
        : (dir_addr == sfacb_pkg::SFR_B) ? b
        : (dir_addr == sfacb_pkg::SFR_PSW) ? program_status_word
        : (dir_addr == sfacb_pkg::SFR_SP) ? sp
        : (dir_addr == sfacb_pkg::SFR_DPL) ? data_pointer[7:0]
        : (dir_addr == sfacb_pkg::SFR_DPH) ? data_pointer[15:8]
        : dir_addr[7] ? 8'h00 : ram[dir_addr];
    // Low opcode bits: 8-f register, 6-7 indirect, 5 direct, 4 immediate
    wire [7:0] add_src = op[3] ? rn_val : op[1] ? ri_val : op[0] ? dir_val : b2;
    wire cin = is_add_with_carry & program_status_word[sfacb_pkg::PSW_CY];
    wire [4:0] sum_lo = {1'b0, acc[3:0]} + {1'b0, add_src[3:0]} + {4'h0, cin};
    wire [7:0] sum_mid = {1'b0, acc[6:0]} + {1'b0, add_src[6:0]} + {7'h00, cin};
    wire [8:0] sum_all = {1'b0, acc} + {1'b0, add_src} + {8'h00, cin};
    wire add_ov = sum_mid[7] ^ sum_all[8];
    wire [7:0] cj_dest = op[3] ? rn_val : op[1] ? ri_val : acc;
    wire [7:0] cj_src = (op[0] & ~op[1] & ~op[3]) ? dir_val : b2;
    wire [7:0] dj_dec = (is_djnz_d ? dir_val : rn_val) - 8'h01;
    wire [7:0] bit_mask = 8'h01 << b2[2:0];
    wire [7:0] bit_new = (op == sfacb_pkg::OP_SETBB) ? (dir_val | bit_mask)
        : (op == sfacb_pkg::OP_CLRB) ? (dir_val & ~bit_mask) : (dir_val ^ bit_mask);
    wire [15:0] prod = acc * b;
    wire b_zero = (b == 8'h00);
    wire [7:0] quot = b_zero ? acc : acc / b;
    wire [7:0] remd = b_zero ? b : acc % b;
    wire [7:0] rel = (is_cjne | is_djnz_d) ? b3 : b2;
    wire [15:0] rel_ext = {{8{rel[7]}}, rel};
    wire [15:0] ret_addr = pc + 16'h0002;
    wire wb_en = is_c1 & (is_djnz_r | is_djnz_d | is_bitop);
    wire [7:0] wb_addr = is_djnz_r ? rn_addr : dir_addr;
    wire [7:0] wb_data = is_bitop ? bit_new : dj_dec;
    wire dwr_acc = wb_en && wb_addr == sfacb_pkg::SFR_ACC;
    wire dwr_b = wb_en && wb_addr == sfacb_pkg::SFR_B;
    wire dwr_psw = wb_en && wb_addr == sfacb_pkg::SFR_PSW;
    wire dwr_sp = wb_en && wb_addr == sfacb_pkg::SFR_SP;
    wire dwr_dpl = wb_en && wb_addr == sfacb_pkg::SFR_DPL;
    wire dwr_dph = wb_en && wb_addr == sfacb_pkg::SFR_DPH;

    // Length, cycle count and next program counter
    always_comb begin
        logic [15:0] base;
        base = pc;
        next_len = 2'd1;
        next_two = 1'b1;
        next_legal = 1'b1;
        if (is_add | is_add_with_carry) begin
            next_len = (op[3] | op[1]) ? 2'd1 : 2'd2;
            next_two = 1'b0;
        end else if (is_absolute_call | (op == sfacb_pkg::OP_SJMP) | (op == sfacb_pkg::OP_JZ)
                | (op == sfacb_pkg::OP_JNZ) | is_djnz_r | is_bitop) begin
            next_len = 2'd2;
            next_two = ~is_bitop;
        end else if (is_cjne | is_djnz_d) begin
            next_len = 2'd3;
        end else if ((op == sfacb_pkg::OP_CLRC) | (op == sfacb_pkg::OP_SETBC)
                | (op == sfacb_pkg::OP_CPLC)) begin
            next_two = 1'b0;
        end else if ((op != sfacb_pkg::OP_JMPA) && (op != sfacb_pkg::OP_MUL)
                && (op != sfacb_pkg::OP_DIV)) begin
            next_len = 2'd0;
            next_two = 1'b0;
            next_legal = 1'b0;
        end
        base = pc + {14'h0000, next_len};
        next_target = base;
        if (is_absolute_call) next_target = {base[15:11], op[7:5], b2};
        else if ((op == sfacb_pkg::OP_SJMP) || (op == sfacb_pkg::OP_JZ && acc == 8'h00)
                || (op == sfacb_pkg::OP_JNZ && acc != 8'h00)
                || (is_cjne && cj_dest != cj_src)
                || ((is_djnz_r | is_djnz_d) && dj_dec != 8'h00))
            next_target = base + rel_ext;
        else if (op == sfacb_pkg::OP_JMPA) next_target = data_pointer + {8'h00, acc};
    end

    // ****************************
    // Architectural registers
    // ****************************
    wire exec = is_c1 & next_legal;
    always_comb begin
        next_acc = wr_acc ? w_data_q[7:0] : acc;
        next_b = wr_b ? w_data_q[7:0] : b;
        next_sp = wr_sp ? w_data_q[7:0] : sp;
        next_data_pointer = data_pointer;
        if (wr_data_pointer && w_strb_q[0]) next_data_pointer[7:0] = w_data_q[7:0];
        if (wr_data_pointer && w_strb_q[1]) next_data_pointer[15:8] = w_data_q[15:8];
        next_psw = wr_psw ? w_data_q[7:0] : program_status_word;
        if (exec) begin
            if (is_add | is_add_with_carry) begin
                next_acc = sum_all[7:0];
                next_psw[sfacb_pkg::PSW_CY] = sum_all[8];
                next_psw[sfacb_pkg::PSW_AC] = sum_lo[4];
                next_psw[sfacb_pkg::PSW_OV] = add_ov;
            end
            if (is_cjne) next_psw[sfacb_pkg::PSW_CY] = (cj_dest < cj_src);
            if (op == sfacb_pkg::OP_MUL) begin
                next_acc = prod[7:0];
                next_b = prod[15:8];
                next_psw[sfacb_pkg::PSW_CY] = 1'b0;
                next_psw[sfacb_pkg::PSW_OV] = (prod[15:8] != 8'h00);
            end
            if (op == sfacb_pkg::OP_DIV) begin
                next_acc = quot;
                next_b = remd;
                next_psw[sfacb_pkg::PSW_CY] = 1'b0;
                next_psw[sfacb_pkg::PSW_OV] = b_zero;
            end
            // Carry as Boolean accumulator
            if (op == sfacb_pkg::OP_CLRC) next_psw[sfacb_pkg::PSW_CY] = 1'b0;
            if (op == sfacb_pkg::OP_SETBC) next_psw[sfacb_pkg::PSW_CY] = 1'b1;
            if (op == sfacb_pkg::OP_CPLC) next_psw[sfacb_pkg::PSW_CY] = ~program_status_word[sfacb_pkg::PSW_CY];
            if (is_absolute_call) next_sp = sp + 8'h01;
            if (dwr_acc) next_acc = wb_data;
            if (dwr_b) next_b = wb_data;
            if (dwr_psw) next_psw = wb_data;
            if (dwr_sp) next_sp = wb_data;
            if (dwr_dpl) next_data_pointer[7:0] = wb_data;
            if (dwr_dph) next_data_pointer[15:8] = wb_data;
        end
        if (is_c2 && is_absolute_call) next_sp = sp + 8'h01;
        next_psw[sfacb_pkg::PSW_RSV] = 1'b0;
        next_psw[sfacb_pkg::PSW_P] = ^next_acc;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc <= 8'h00;
            b <= 8'h00;
            program_status_word <= sfacb_pkg::PSW_RST;
            sp <= sfacb_pkg::SP_RST;
            data_pointer <= 16'h0000;
        end else begin
            acc <= next_acc;
            b <= next_b;
            program_status_word <= next_psw;
            sp <= next_sp;
            data_pointer <= next_data_pointer;
        end
    end

    // ****************************
    // Data memory write port
    // ****************************
    always_comb begin
        ram_we = 1'b0;
        ram_wa = sp + 8'h01;
        ram_wd = ret_addr[7:0];
        if ((exec | is_c2) && is_absolute_call) begin
            ram_we = 1'b1;
            ram_wd = is_c2 ? ret_addr[15:8] : ret_addr[7:0];
        end else if (wb_en && !wb_addr[7]) begin
            ram_we = 1'b1;
            ram_wa = wb_addr;
            ram_wd = wb_data;
        end else if (do_wr && wr_ram && w_strb_q[0]) begin
            ram_we = 1'b1;
            ram_wa = aw_addr_q[9:2];
            ram_wd = w_data_q[7:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (ram_we) ram[ram_wa] <= ram_wd;
    end

    // ****************************
    // Sequencer and program counter
    // ****************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= sfacb_pkg::ST_IDLE;
            pc <= 16'h0000;
            target_q <= 16'h0000;
            op <= 8'h00;
            b2 <= 8'h00;
            b3 <= 8'h00;
            bad_op <= 1'b0;
        end else begin
            unique case (state)
                sfacb_pkg::ST_IDLE: begin
                    if (wr_cmd && w_strb_q[0]) op <= w_data_q[7:0];
                    if (wr_cmd && w_strb_q[1]) b2 <= w_data_q[15:8];
                    if (wr_cmd && w_strb_q[2]) b3 <= w_data_q[23:16];
                    if (wr_pc && w_strb_q[0]) pc[7:0] <= w_data_q[7:0];
                    if (wr_pc && w_strb_q[1]) pc[15:8] <= w_data_q[15:8];
                    if (start) begin
                        bad_op <= 1'b0;
                        state <= sfacb_pkg::ST_CYC1;
                    end
                end
                sfacb_pkg::ST_CYC1: begin
                    target_q <= next_target;
                    bad_op <= ~next_legal;
                    if (next_two) begin
                        state <= sfacb_pkg::ST_CYC2;
                    end else begin
                        pc <= next_target;
                        state <= sfacb_pkg::ST_IDLE;
                    end
                end
                sfacb_pkg::ST_CYC2: begin
                    pc <= target_q;
                    state <= sfacb_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************
    // Checks
    // ****************************
    wire [6:0] psw_hi = program_status_word[7:1];
    wire [8:0] chk_sum = {1'b0, acc} + {1'b0, add_src};
    AST_REL_SJMP: assert property (
        (is_c1 && op == sfacb_pkg::OP_SJMP) |-> ##2 (pc == $past(pc, 2) + 16'h0002
            + $past(rel_ext, 2))) else $error("short jump target wrong");
    AST_JZ_FALL: assert property (
        (is_c1 && op == sfacb_pkg::OP_JZ && acc != 8'h00) |-> ##2
            (pc == $past(pc, 2) + 16'h0002)) else $error("zero test branched wrongly");
    AST_DJNZ_LAST: assert property (
        (is_c1 && is_djnz_r && rn_val == 8'h01) |-> ##2
            (pc == $past(pc, 2) + 16'h0002)) else $error("decrement loop not exited");
    AST_JMPA: assert property (
        (is_c1 && op == sfacb_pkg::OP_JMPA) |-> ##2
            (pc == $past(data_pointer, 2) + {8'h00, $past(acc, 2)})) else $error("indirect jump wrong");
    AST_RSV_ZERO: assert property (program_status_word[sfacb_pkg::PSW_RSV] == 1'b0)
        else $error("reserved bit set");
    AST_ADD_CY: assert property (
        (exec && is_add) |=> (program_status_word[sfacb_pkg::PSW_CY] == $past(chk_sum[8])))
        else $error("add carry wrong");
    AST_DIV_OV: assert property (
        (exec && op == sfacb_pkg::OP_DIV && b_zero) |=> program_status_word[sfacb_pkg::PSW_OV])
        else $error("divide by zero not flagged");
    AST_PARITY: assert property (1'b1 |=> (program_status_word[sfacb_pkg::PSW_P] == ^acc))
        else $error("parity stale");
    AST_ADD_ONE: assert property (
        (is_c1 && is_add) |=> is_idle) else $error("add not single cycle");
    AST_ABSOLUTE_CALL_SP: assert property (
        (is_c1 && is_absolute_call) |-> ##2 (sp == $past(sp, 2) + 8'h02 && is_idle))
        else $error("call stack pointer wrong");
    AST_ABSOLUTE_CALL_PAGE: assert property (
        (is_c1 && is_absolute_call) |-> ##2 (pc[15:11] == $past(ret_addr[15:11], 2)
            && pc[7:0] == $past(b2, 2))) else $error("call target wrong");
    AST_ABSOLUTE_CALL_FLAGS: assert property (
        (is_c1 && is_absolute_call) |-> ##2 (psw_hi == $past(psw_hi, 2)))
        else $error("call changed flags");
endmodule
`default_nettype wire

// file: test/sfacb_core_tb.sv
// Self-checking bench for the status-flag, add, call and branch unit
`timescale 1ns/1ps
`default_nettype none
module sfacb_core_tb;
    // ****************************
    // Signals and instance
    // ****************************
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rd_r, wr_r;
    logic [31:0] rdata, rd_d;
    int fail_count = 0;
    int n_checks = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    sfacb_core dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready));
    // ****************************
    // Bus and check tasks
    // ****************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        wr_r = bresp;
        bready <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic rd(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd_d = rdata;
        rd_r = rresp;
        rready <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    // Start one instruction, then poll until idle
    task automatic ex(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3);
        wr(12'h000, {8'h01, b3, b2, op});
        do rd(12'h004); while (rd_d[0] !== 1'b0);
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ****************************
    // Scenarios
    // ****************************
    task automatic t_add();
        wr(12'h008, 32'hc3);
        wr(12'h420, 32'haa);
        wr(12'h010, 32'h08);
        ex(8'h28, 8'h00, 8'h00);
        rd(12'h008);
        chk("add_acc", rd_d, 32'h6d);
        rd(12'h010);
        chk("add_psw", rd_d, 32'h8d);
    endtask
    task automatic t_add_with_carry();
        wr(12'h008, 32'h0f);
        wr(12'h010, 32'h80);
        ex(8'h34, 8'h00, 8'h00);
        rd(12'h008);
        chk("add_with_carry_acc", rd_d, 32'h10);
        rd(12'h010);
        chk("add_with_carry_psw", rd_d, 32'h41);
    endtask
    task automatic t_call();
        wr(12'h014, 32'h0123);
        wr(12'h018, 32'h07);
        ex(8'h71, 8'h45, 8'h00);
        rd(12'h014);
        chk("call_pc", rd_d, 32'h0345);
        rd(12'h018);
        chk("call_sp", rd_d, 32'h09);
        rd(12'h420);
        chk("call_lo", rd_d, 32'h25);
        rd(12'h424);
        chk("call_hi", rd_d, 32'h01);
        rd(12'h010);
        chk("call_psw", rd_d, 32'h41);
    endtask
    task automatic t_branch();
        wr(12'h008, 32'h00);
        wr(12'h014, 32'h0200);
        ex(8'h60, 8'h80, 8'h00);
        rd(12'h014);
        chk("jz_back", rd_d, 32'h0182);
        ex(8'h70, 8'h7f, 8'h00);
        rd(12'h014);
        chk("jnz_fall", rd_d, 32'h0184);
        wr(12'h01c, 32'h1000);
        wr(12'h008, 32'hff);
        ex(8'h73, 8'h00, 8'h00);
        rd(12'h014);
        chk("jmp_ind", rd_d, 32'h10ff);
        ex(8'hb4, 8'h00, 8'h10);
        rd(12'h014);
        chk("cjne_pc", rd_d, 32'h1112);
        rd(12'h100);
        chk("rresp", {30'h0, rd_r}, 32'h2);
        wr(12'h100, 32'h5a);
        chk("bresp", {30'h0, wr_r}, 32'h2);
    endtask
    // Divide, multiply, carry bit, bit set, loop exit and short jump
    task automatic t_more();
        wr(12'h010, 32'h00);
        wr(12'h008, 32'h80);
        wr(12'h00c, 32'h00);
        wr(12'h014, 32'h0300);
        ex(8'h84, 8'h00, 8'h00);
        rd(12'h010);
        chk("div_psw", rd_d, 32'h05);
        ex(8'h60, 8'h10, 8'h00);
        wr(12'h00c, 32'h04);
        ex(8'ha4, 8'h00, 8'h00);
        rd(12'h00c);
        chk("mul_b", rd_d, 32'h02);
        rd(12'h010);
        chk("mul_psw", rd_d, 32'h04);
        ex(8'hd3, 8'h00, 8'h00);
        rd(12'h010);
        chk("setb_cy", rd_d, 32'h84);
        ex(8'hb2, 8'hd7, 8'h00);
        ex(8'hd2, 8'hd5, 8'h00);
        rd(12'h010);
        chk("bit_psw", rd_d, 32'h24);
        wr(12'h408, 32'h01);
        ex(8'hda, 8'hf0, 8'h00);
        rd(12'h408);
        chk("djnz_r2", rd_d, 32'h00);
        ex(8'h80, 8'h7f, 8'h00);
        rd(12'h014);
        chk("sjmp_pc", rd_d, 32'h038c);
    endtask
    initial begin
        #500000;
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        rd(12'h010);
        chk("psw_rst", rd_d, 32'h00);
        rd(12'h018);
        chk("sp_rst", rd_d, 32'h07);
        t_add();
        t_add_with_carry();
        t_call();
        t_branch();
        t_more();
        end_sim();
    end
endmodule
`default_nettype wire
